// file: rtl/psc_pkg.sv
// ----------------------------------------------------------------------------
// Purpose : Shared constants and types for the pipelined SRAM pin control
// Assumes : Four byte lanes of eight data bits plus one parity bit each
// Notes   : Lane a is lane index 0, lane d is lane index 3
// ----------------------------------------------------------------------------
package psc_pkg;

	// ------------------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------------------
	localparam int ADDR_W    = 18;
	localparam int LANES     = 4;
	localparam int BYTE_W    = 8;
	localparam int LANE_W    = BYTE_W + 1;
	localparam int DATA_W    = LANES * BYTE_W;
	localparam int WORD_W    = LANES * LANE_W;
	localparam int BURST_W   = 2;

	// ------------------------------------------------------------------------
	// Strap and reset values
	// ------------------------------------------------------------------------
	localparam logic MODE_INTERLEAVED = 1'b1;
	localparam logic MODE_LINEAR      = 1'b0;
	localparam logic MODE_RESET       = MODE_INTERLEAVED;
	localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
	localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;

	// ------------------------------------------------------------------------
	// Pipeline carriers
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} psc_op_e;

	typedef struct packed {
		psc_op_e             op;
		logic [ADDR_W-1:0]   addr;
		logic [LANES-1:0]    bws_n;
	} psc_cmd_s;

	localparam psc_cmd_s CMD_IDLE = '{op: OP_IDLE, addr: 18'h00000, bws_n: 4'hF};

endpackage : psc_pkg

// file: rtl/psc_burst_seq.sv
// ----------------------------------------------------------------------------
// Purpose : Two-bit burst counter and burst order for four-word bursts
// Assumes : step_in is high on every edge that the clock gate lets through
// Notes   : Offset reflects the value the counter takes at this edge
// ----------------------------------------------------------------------------
`timescale 1ns/10ps

module psc_burst_seq
	import psc_pkg::*;
(
	input  wire logic               clk_in,      // Core clock
	input  wire logic               rst_n_in,    // Async reset, active low
	input  wire logic               step_in,     // Edge is recognised
	input  wire logic               load_in,     // Load new start address
	input  wire logic               advance_in,  // Advance burst count
	input  wire logic               mode_in,     // High interleaved, low linear
	input  wire logic [BURST_W-1:0] low_in,      // Start address low bits
	output logic      [BURST_W-1:0] offset_out   // Burst address low bits
);

	logic [BURST_W-1:0] cnt_r;
	logic [BURST_W-1:0] cnt_nxt;
	logic [BURST_W-1:0] base_r;
	logic [BURST_W-1:0] base_nxt;
	logic [BURST_W-1:0] lin_sum;

	assign cnt_nxt    = !step_in ? cnt_r : (load_in ? BURST_ZERO : (advance_in ? cnt_r + BURST_ONE : cnt_r));
	assign base_nxt   = (step_in && load_in) ? low_in : base_r;
	assign lin_sum    = base_nxt + cnt_nxt;
	assign offset_out = (mode_in == MODE_INTERLEAVED) ? (base_nxt ^ cnt_nxt) : lin_sum;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt_r  <= BURST_ZERO;
			base_r <= BURST_ZERO;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			base_r <= base_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	AST_BURST_STEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		step_in && advance_in && !load_in |=> cnt_r == $past(cnt_r) + BURST_ONE)
		else $error("burst count did not advance");

	AST_BURST_START: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		step_in && load_in |-> offset_out == low_in)
		else $error("burst does not start at loaded address");

endmodule : psc_burst_seq

// file: rtl/psc_store.sv
// ----------------------------------------------------------------------------
// Purpose : Memory array with per-lane write enables
// Assumes : Read is combinational, write lands on the clock edge
// Notes   : Reset only disables the checks; the array itself is not cleared
// ----------------------------------------------------------------------------
`timescale 1ns/10ps

module psc_store
	import psc_pkg::*;
#(
	parameter int MEM_AW = ADDR_W
)
(
	input  wire logic              clk_in,      // Core clock
	input  wire logic              rst_n_in,    // Reset, checks only
	input  wire logic              we_in,       // Write this edge
	input  wire logic [MEM_AW-1:0] wr_addr_in,  // Write address
	input  wire logic [LANES-1:0]  byte_en_in,  // Lane write enables
	input  wire logic [WORD_W-1:0] wdata_in,    // Write word
	input  wire logic [MEM_AW-1:0] rd_addr_in,  // Read address
	output logic      [WORD_W-1:0] rdata_out    // Read word
);

	logic [LANE_W-1:0] lane_a_wdata;

	assign lane_a_wdata = wdata_in[LANE_W-1:0];

	// ------------------------------------------------------------------------
	// Lane writes
	// ------------------------------------------------------------------------
	for (genvar i = 0; i < LANES; i++)
	begin : g_lane
		// One array per lane keeps a single writing process for each
		logic [LANE_W-1:0] lane_mem [2**MEM_AW];

		assign rdata_out[i*LANE_W +: LANE_W] = lane_mem[rd_addr_in];

		always_ff @(posedge clk_in)
		begin
			if (we_in && byte_en_in[i])
				lane_mem[wr_addr_in] <= wdata_in[i*LANE_W +: LANE_W];
		end
	end

	AST_WRITE_CAPTURE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		we_in && byte_en_in[0] |=> g_lane[0].lane_mem[$past(wr_addr_in)] == $past(lane_a_wdata))
		else $error("lane a write not captured");

endmodule : psc_store

// file: rtl/psc_sram_pins.sv
// ----------------------------------------------------------------------------
// Purpose : Device-side pin control of a pipelined burst SRAM
// Assumes : Inputs synchronous to clk_in; read data drives after the edge
//           that follows the address edge, write data is taken one edge later
// Notes   : Output drive enable is a live pin, so the lane enables pass
//           through one gate after the drive flop
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Third chip select, active low, sampled each edge with the other two.
// - Output drive enable low lets lanes drive; high tri-states them.
// - Lanes float in write data phase, first clock after deselect, while deselected.
// - Edges count only while the clock gate is low.
// - Clock gate high stretches the cycle; state held, no deselect.
// - Input lanes are captured into the data register on the edge.
// - Read drives data of the 18-bit address captured earlier.
// - Parity lanes behave as a ninth bit of each byte lane.
// - Each parity bit is written only with its own byte write select.
// - Burst strap high picks interleaved order, low picks linear.
// - A floating burst strap counts as high, interleaved. Here only reset loads high; an open strap is sampled as it is.
// - Byte write selects, active low, gate their lane on write edges.
// - Advance/load high advances the burst; low loads a new address.
`timescale 1ns/10ps

module psc_sram_pins
	import psc_pkg::*;
#(
	parameter int MEM_AW = ADDR_W
)
(
	input  wire logic               clk_in,                  // Core clock
	input  wire logic               rst_n_in,                // Async reset, active low
	input  wire logic [ADDR_W-1:0]  addr_in,                 // Address
	input  wire logic               write_n_in,              // Write strobe, active low
	input  wire logic               advance_or_load_in,      // High advance, low load
	input  wire logic               chip_select_first_n_in,  // Chip select, active low
	input  wire logic               chip_select_second_in,   // Chip select, active high
	input  wire logic               chip_select_third_n_in,  // Chip select, active low
	input  wire logic               clock_gate_n_in,         // Clock gate, active low
	input  wire logic [LANES-1:0]   byte_write_select_n_in,  // Lane write selects, a..d
	input  wire logic               output_drive_n_in,       // Async output enable, low
	input  wire logic               burst_mode_in,           // Burst order strap
	input  wire logic [DATA_W-1:0]  data_lane_in,            // Data lanes in, a=[7:0]
	output logic      [DATA_W-1:0]  data_lane_out,           // Data lanes out
	output logic                    data_lane_oe_out,        // Data lanes drive
	input  wire logic [LANES-1:0]   parity_lane_in,          // Parity lanes in, a=[0]
	output logic      [LANES-1:0]   parity_lane_out,         // Parity lanes out
	output logic                    parity_lane_oe_out       // Parity lanes drive
);

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	wire logic               step;
	wire logic               selected;
	wire logic               new_load;
	wire logic               do_adv;
	wire logic               stop_burst;
	wire logic [BURST_W-1:0] burst_low;
	wire logic [WORD_W-1:0]  in_word;
	wire logic [WORD_W-1:0]  mem_word;
	wire logic [WORD_W-1:0]  rd_word;
	wire logic               wr_now;
	wire logic               rd_now;
	wire logic               hit;
	wire psc_op_e            load_op;
	wire psc_cmd_s           load_cmd;
	wire psc_cmd_s           adv_cmd;

	logic                    mode_r;
	logic                    burst_live_r;
	logic                    burst_live_nxt;
	psc_op_e                 last_op_r;
	psc_op_e                 last_op_nxt;
	logic [ADDR_W-1:0]       last_addr_r;
	logic [ADDR_W-1:0]       last_addr_nxt;
	psc_cmd_s                s1_r;
	psc_cmd_s                s1_nxt;
	psc_cmd_s                s2_r;
	psc_cmd_s                s2_nxt;
	logic [WORD_W-1:0]       dout_r;
	logic [WORD_W-1:0]       dout_nxt;
	logic                    drive_r;
	logic                    drive_nxt;

	assign step       = !clock_gate_n_in;
	assign selected   = !chip_select_first_n_in && chip_select_second_in && !chip_select_third_n_in;
	assign new_load   = !advance_or_load_in && selected;
	assign do_adv     = advance_or_load_in && burst_live_r;
	assign stop_burst = !advance_or_load_in && !selected;
	assign load_op    = write_n_in ? OP_READ : OP_WRITE;

	assign load_cmd   = '{op: load_op, addr: addr_in, bws_n: byte_write_select_n_in};
	assign adv_cmd    = '{op: last_op_r,
	                      addr: {last_addr_r[ADDR_W-1:BURST_W], burst_low},
	                      bws_n: byte_write_select_n_in};

	// Lane packing: each lane carries its parity as the ninth bit
	for (genvar i = 0; i < LANES; i++)
	begin : g_pack
		assign in_word[i*LANE_W +: LANE_W] = {parity_lane_in[i], data_lane_in[i*BYTE_W +: BYTE_W]};
		assign rd_word[i*LANE_W +: LANE_W] = (hit && !s2_r.bws_n[i]) ?
		                                     in_word[i*LANE_W +: LANE_W] :
		                                     mem_word[i*LANE_W +: LANE_W];
	end

	// ------------------------------------------------------------------------
	// Data phase control
	// ------------------------------------------------------------------------
	// Write data is taken on the edge after the write reaches stage two
	assign wr_now = step && (s2_r.op == OP_WRITE);
	assign rd_now = step && (s1_r.op == OP_READ);
	// Back-to-back write then read of one word must see the new bytes
	assign hit    = (s2_r.op == OP_WRITE) && (s2_r.addr == s1_r.addr);

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb
	begin
		s1_nxt         = s1_r;
		burst_live_nxt = burst_live_r;
		last_op_nxt    = last_op_r;
		last_addr_nxt  = last_addr_r;
		if (step)
		begin
			if (new_load)
			begin
				s1_nxt         = load_cmd;
				burst_live_nxt = 1'b1;
				last_op_nxt    = load_op;
				last_addr_nxt  = addr_in;
			end
			else if (do_adv)
			begin
				s1_nxt         = adv_cmd;
			end
			else
			begin
				s1_nxt         = CMD_IDLE;
				burst_live_nxt = stop_burst ? 1'b0 : burst_live_r;
			end
		end
	end

	assign s2_nxt    = step ? s1_r : s2_r;
	assign dout_nxt  = rd_now ? rd_word : dout_r;
	// Only a read reaching its data phase turns the drivers on, so a write
	// phase, a deselect and the first clock after one all stay floating
	assign drive_nxt = step ? (s1_r.op == OP_READ) : drive_r;

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s1_r         <= CMD_IDLE;
			s2_r         <= CMD_IDLE;
			burst_live_r <= 1'b0;
			last_op_r    <= OP_IDLE;
			last_addr_r  <= 18'h00000;
		end
		else
		begin
			s1_r         <= s1_nxt;
			s2_r         <= s2_nxt;
			burst_live_r <= burst_live_nxt;
			last_op_r    <= last_op_nxt;
			last_addr_r  <= last_addr_nxt;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			dout_r  <= 36'h000000000;
			drive_r <= 1'b0;
		end
		else
		begin
			dout_r  <= dout_nxt;
			drive_r <= drive_nxt;
		end
	end

	// Strap sampled every clock after release; nothing here pulls an open
	// strap high, only the reset value loads the high, interleaved default
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			mode_r <= MODE_RESET;
		else
			mode_r <= burst_mode_in;
	end

	// ------------------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------------------
	for (genvar i = 0; i < LANES; i++)
	begin : g_out
		assign data_lane_out[i*BYTE_W +: BYTE_W] = dout_r[i*LANE_W +: BYTE_W];
		assign parity_lane_out[i]                = dout_r[i*LANE_W + BYTE_W];
	end

	// Output drive enable is asynchronous, so it gates the drive flop directly
	assign data_lane_oe_out   = drive_r && !output_drive_n_in;
	assign parity_lane_oe_out = drive_r && !output_drive_n_in;

	// ------------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------------
	psc_burst_seq u_burst (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.step_in    (step),
		.load_in    (new_load),
		.advance_in (do_adv),
		.mode_in    (mode_r),
		.low_in     (addr_in[BURST_W-1:0]),
		.offset_out (burst_low)
	);

	psc_store #(
		.MEM_AW (MEM_AW)
	) u_store (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.we_in      (wr_now),
		.wr_addr_in (s2_r.addr[MEM_AW-1:0]),
		.byte_en_in (~s2_r.bws_n),
		.wdata_in   (in_word),
		.rd_addr_in (s1_r.addr[MEM_AW-1:0]),
		.rdata_out  (mem_word)
	);

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_DESELECT_IDLE: assert property (
		step && !advance_or_load_in && chip_select_third_n_in |=> s1_r.op == OP_IDLE)
		else $error("deselect did not end the operation");

	AST_OE_MASK: assert property (
		output_drive_n_in |-> !data_lane_oe_out && !parity_lane_oe_out)
		else $error("lanes drive with output enable high");

	AST_WRITE_FLOAT: assert property (
		s2_r.op == OP_WRITE || s1_r.op == OP_IDLE && $past(s1_r.op) == OP_IDLE && $past(step) |-> !drive_r)
		else $error("lanes driven in write phase or while deselected");

	AST_GATE_HOLD: assert property (
		!step |=> $stable(s1_r) && $stable(s2_r) && $stable(dout_r) && $stable(drive_r))
		else $error("state moved while clock gate high");

	AST_LOAD_ADDR: assert property (
		step && new_load |=> s1_r.addr == $past(addr_in))
		else $error("loaded address lost");

	AST_READ_DRIVE: assert property (
		step && new_load && write_n_in ##1 step |=> drive_r && dout_r == $past(rd_word))
		else $error("read data not driven one edge after address edge");

	AST_PARITY_TIE: assert property (
		parity_lane_oe_out == data_lane_oe_out)
		else $error("parity lanes differ from data lanes");

	AST_WRITE_EDGE: assert property (
		step && new_load && !write_n_in ##1 step ##1 step |-> wr_now && s2_r.addr == $past(s1_r.addr))
		else $error("write did not reach its data stage");

	AST_LANE_GATE: assert property (
		wr_now |-> s2_r.bws_n == $past(s1_r.bws_n, 1) || !$past(step))
		else $error("byte selects not carried with the write");

	// Any inactive select on a load refuses it and ends a live burst
	AST_SELECT_ANY: assert property (
		step && !advance_or_load_in && (chip_select_first_n_in || !chip_select_second_in || chip_select_third_n_in)
		|=> s1_r.op == OP_IDLE && !burst_live_r)
		else $error("load accepted with a select inactive");

	// A stopped burst must not resume on a stray advance
	AST_ADV_DEAD: assert property (
		step && advance_or_load_in && !burst_live_r |=> s1_r.op == OP_IDLE)
		else $error("advance accepted with no live burst");

	// Burst bookkeeping holds through a stretch as well
	AST_GATE_BURST: assert property (
		!step |=> $stable(burst_live_r) && $stable(last_op_r) && $stable(last_addr_r))
		else $error("burst state moved while clock gate high");

	// Covers for the main traffic shapes
	C_READ: cover property (step && new_load && write_n_in ##1 step ##1 drive_r);
	C_WRITE: cover property (step && new_load && !write_n_in ##1 step ##1 wr_now);
	C_BURST: cover property (step && new_load ##1 step && do_adv ##1 step && do_adv);
	C_STALL: cover property (s1_r.op != OP_IDLE && !step ##1 !step);
	C_BURST_STOP: cover property (step && do_adv ##1 step && stop_burst);

endmodule : psc_sram_pins

// file: verification/psc_ctrl_model.sv
// ----------------------------------------------------------------------------
// Purpose : Memory controller model facing the SRAM pin control block
// Assumes : Commands launch just after a rising edge, write data two commands later
// Notes   : Between write data phases the lanes carry the inverse of the last value
// ----------------------------------------------------------------------------
`timescale 1ns/10ps

module psc_ctrl_model
	import psc_pkg::*;
(
	input  wire logic              clk_in,                   // Core clock
	output logic      [ADDR_W-1:0] addr_out,                 // Address
	output logic                   write_n_out,              // Write strobe, active low
	output logic                   advance_or_load_out,      // High advance, low load
	output logic                   chip_select_first_n_out,  // Chip select one
	output logic                   chip_select_second_out,   // Chip select two
	output logic                   chip_select_third_n_out,  // Chip select three
	output logic                   clock_gate_n_out,         // Clock gate
	output logic      [LANES-1:0]  byte_write_select_n_out,  // Lane write selects
	output logic      [DATA_W-1:0] data_lane_out,            // Write data lanes
	output logic      [LANES-1:0]  parity_lane_out           // Write parity lanes
);
	logic [WORD_W-1:0] w1_r;
	logic [WORD_W-1:0] w2_r;
	logic              v1_r;
	logic              v2_r;

	initial
	begin
		{addr_out, write_n_out, advance_or_load_out} = '0;
		{chip_select_first_n_out, chip_select_second_out, chip_select_third_n_out} = 3'h5;
		{clock_gate_n_out, byte_write_select_n_out} = 5'h1F;
		{data_lane_out, parity_lane_out} = '0;
		{w1_r, w2_r, v1_r, v2_r} = '0;
	end

	// ------------------------------------------------------------------------
	// One command per recognised edge; sel low deselects through select three
	// ------------------------------------------------------------------------
	task automatic issue(input logic adv, wr_n, sel, input logic [ADDR_W-1:0] a,
		input logic [LANES-1:0] bws, input logic [WORD_W-1:0] w);
		@(posedge clk_in);
		clock_gate_n_out        <= 1'b0;
		advance_or_load_out     <= adv;
		write_n_out             <= wr_n;
		chip_select_first_n_out <= 1'b0;
		chip_select_second_out  <= 1'b1;
		chip_select_third_n_out <= ~sel;
		addr_out                <= a;
		byte_write_select_n_out <= bws;
		// Write data belongs to the command issued two edges earlier
		if (v2_r)
		begin
			data_lane_out   <= w2_r[DATA_W-1:0];
			parity_lane_out <= w2_r[WORD_W-1:DATA_W];
		end
		else
		begin
			data_lane_out   <= ~data_lane_out;
			parity_lane_out <= ~parity_lane_out;
		end
		{w2_r, v2_r} = {w1_r, v1_r};
		{w1_r, v1_r} = {w, ~wr_n & sel};
	endtask : issue

	// Masks the following edges; every other pin holds its level
	task automatic hold();
		@(posedge clk_in);
		clock_gate_n_out <= 1'b1;
	endtask : hold

endmodule : psc_ctrl_model

// file: verification/psc_sram_pins_tb_top.sv
// ----------------------------------------------------------------------------
// Purpose : Self-checking bench for the SRAM pin control block
// Assumes : Small array (MEM_AW 4); commands through the controller model
// Notes   : Read data is checked right after the second edge following its load
// ----------------------------------------------------------------------------
`timescale 1ns/10ps

module psc_sram_pins_tb_top;
	import psc_pkg::*;

	logic              clk_in     = 1'b0;
	logic              rst_n_in   = 1'b0;
	logic              oe_n       = 1'b0;
	logic              mode       = 1'b1;
	logic [ADDR_W-1:0] m_addr;
	logic              m_wr_n, m_adv, m_cs1_n, m_cs2, m_cs3_n, m_gate_n;
	logic [LANES-1:0]  m_bws_n, m_par, d_par;
	logic [DATA_W-1:0] m_data, d_data;
	logic              d_oe, d_poe;
	logic [DATA_W-1:0] lane_wire;
	logic [LANES-1:0]  par_wire;
	logic [WORD_W-1:0] word;
	int                fail_count = 0;
	int                n_checks   = 0;

	always #5 clk_in = ~clk_in;

	// Shared pins resolve to whoever drives them
	assign lane_wire = d_oe ? d_data : m_data;
	assign par_wire  = d_poe ? d_par : m_par;
	assign word      = {d_par, d_data};

	psc_ctrl_model u_psc_ctrl_model (.clk_in(clk_in), .addr_out(m_addr), .write_n_out(m_wr_n),
		.advance_or_load_out(m_adv), .chip_select_first_n_out(m_cs1_n), .chip_select_second_out(m_cs2),
		.chip_select_third_n_out(m_cs3_n), .clock_gate_n_out(m_gate_n), .byte_write_select_n_out(m_bws_n),
		.data_lane_out(m_data), .parity_lane_out(m_par));

	psc_sram_pins #(.MEM_AW(4)) u_psc_sram_pins (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(m_addr),
		.write_n_in(m_wr_n), .advance_or_load_in(m_adv), .chip_select_first_n_in(m_cs1_n),
		.chip_select_second_in(m_cs2), .chip_select_third_n_in(m_cs3_n), .clock_gate_n_in(m_gate_n),
		.byte_write_select_n_in(m_bws_n), .output_drive_n_in(oe_n), .burst_mode_in(mode),
		.data_lane_in(lane_wire), .data_lane_out(d_data), .data_lane_oe_out(d_oe),
		.parity_lane_in(par_wire), .parity_lane_out(d_par), .parity_lane_oe_out(d_poe));

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	task automatic chk(input logic [WORD_W-1:0] got, exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
			fail_count++;
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic op(input logic adv, wr_n, sel, input logic [3:0] a, input logic [3:0] bws,
		input logic [WORD_W-1:0] w);
		u_psc_ctrl_model.issue(adv, wr_n, sel, {14'h0000, a}, bws, w);
	endtask : op

	task automatic nop();
		op(1'b0, 1'b1, 1'b0, 4'h0, 4'hF, 36'h000000000);
	endtask : nop

	function automatic logic [WORD_W-1:0] pat(input logic [3:0] a);
		return {32'h00000000, a} * 36'h111111111;
	endfunction : pat

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_write_read();
		op(1'b0, 1'b0, 1'b1, 4'h3, 4'h0, pat(4'h3));
		nop();
		nop();
		op(1'b0, 1'b1, 1'b1, 4'h3, 4'hF, 36'h000000000);
		nop();
		u_psc_ctrl_model.hold();
		#1 chk(word, pat(4'h3), "read word");
		chk({35'h0, d_oe & d_poe}, 36'h1, "read drive");
		u_psc_ctrl_model.hold();
		oe_n <= 1'b1;
		#1 chk({35'h0, d_oe | d_poe}, 36'h0, "drive off by enable");
		u_psc_ctrl_model.hold();
		oe_n <= 1'b0;
		#1 chk(word, pat(4'h3), "stretched word");
		chk({35'h0, d_oe}, 36'h1, "stretched drive");
		nop();
		nop();
		#1 chk({35'h0, d_oe | d_poe}, 36'h0, "drive after read");
		$display("t_write_read done");
	endtask : t_write_read

	task automatic t_bytes();
		logic [WORD_W-1:0] e;
		for (int i = 0; i < 4; i++)
		begin
			e = pat(4'h2) | ({4'h0, 32'h000000FF} << (8 * i)) | (36'h100000000 << i);
			op(1'b0, 1'b0, 1'b1, 4'h2, 4'h0, pat(4'h2));
			op(1'b0, 1'b0, 1'b1, 4'h2, ~(4'h1 << i), 36'hFFFFFFFFF);
			nop();
			#1 chk({35'h0, d_oe | d_poe}, 36'h0, "write data phase");
			nop();
			op(1'b0, 1'b1, 1'b1, 4'h2, 4'hF, 36'h000000000);
			nop();
			nop();
			#1 chk(word, e, "lane mask");
		end
		$display("t_bytes done");
	endtask : t_bytes

	task automatic t_desel();
		op(1'b0, 1'b1, 1'b0, 4'h3, 4'hF, 36'h000000000);
		op(1'b1, 1'b1, 1'b1, 4'h3, 4'hF, 36'h000000000);
		nop();
		nop();
		#1 chk({35'h0, d_oe | d_poe}, 36'h0, "deselected read");
		$display("t_desel done");
	endtask : t_desel

	task automatic t_burst(input logic m);
		logic [1:0] lo;
		mode <= m;
		for (int i = 4; i < 8; i++)
			op(1'b0, 1'b0, 1'b1, 4'(i), 4'h0, pat(4'(i)));
		nop();
		nop();
		op(1'b0, 1'b1, 1'b1, 4'h5, 4'hF, 36'h000000000);
		for (int k = 1; k < 6; k++)
		begin
			if (k < 4)
				op(1'b1, 1'b1, 1'b1, 4'h0, 4'hF, 36'h000000000);
			else
				nop();
			lo = m ? (2'h1 ^ 2'(k - 2)) : (2'h1 + 2'(k - 2));
			if (k >= 2)
				#1 chk(word, pat({2'h1, lo}), "burst word");
		end
		$display("t_burst done mode %0b", m);
	endtask : t_burst

	// ------------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1 chk(word, 36'h000000000, "reset outputs");
		chk({34'h0, d_oe, d_poe}, 36'h000000000, "reset drive");
		t_write_read();
		t_bytes();
		t_desel();
		t_burst(1'b1);
		t_burst(1'b0);
		stop_test();
	end

	initial
	begin
		#100000;
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end

endmodule : psc_sram_pins_tb_top
